// File: rtl/mcit_core_timing.sv
// Purpose: Issue and cycle sequencing of decoded instructions.
// Assumes: Opcode arrives with its branch condition already resolved.
// Notes:   Each accepted instruction occupies exactly its cycle count plus one when its branch is taken.
module mcit_core_timing
    import mcit_pkg::*;
(
    input wire logic mclk,          // System clock
    input wire logic rst,           // Synchronous reset, active high
    input wire logic opValid,       // Opcode byte offered
    input wire logic [7:0] opByte,  // Opcode byte
    input wire logic condTrue,      // Branch condition of offered op
    output logic opReady,           // Sequencer takes an opcode now
    output logic opDone,            // Last cycle of current instruction
    output logic busy,              // An instruction is executing
    output logic branchTaken,       // Current branch is taken
    output logic illegalOp,         // Current opcode is reserved
    output logic [3:0] cycleIndex,  // Cycle number within instruction
    output logic [7:0] curOp,       // Opcode being executed
    output mcit_dec_s instrInfo     // Decoded attributes of current op
);

    mcit_seq_s s_ff;
    mcit_seq_s nxt_s;
    mcit_dec_s dec;
    logic accept;
    logic lastCyc;
    logic takenNow;

    // ==================================================================
    // Decoder
    // ==================================================================
    mcit_decoder u_dec (
        .opByte(opByte),
        .dec(dec)
    );

    // ==================================================================
    // Handshake
    // ==================================================================
    assign lastCyc = (s_ff.st == ST_EXEC) && (s_ff.remain == CNT_ZERO);
    assign opReady = (s_ff.st == ST_IDLE) || lastCyc;
    assign accept = opValid && opReady;
    assign takenNow = dec.cond && condTrue;

    // ==================================================================
    // Sequencer
    // ==================================================================
    always_comb begin
        nxt_s = s_ff;
        case (s_ff.st)
            ST_IDLE: nxt_s.st = ST_IDLE;
            ST_EXEC: begin
                nxt_s.remain = s_ff.remain - CNT_ONE;
                nxt_s.elapsed = s_ff.elapsed + CNT_ONE;
                if (lastCyc) begin
                    // Index holds its final count until the next take
                    nxt_s.st = ST_IDLE;
                    nxt_s.remain = CNT_ZERO;
                    nxt_s.elapsed = s_ff.elapsed;
                end
            end
            default: nxt_s = SEQ_RESET;
        endcase
        if (accept) begin
            nxt_s.st = ST_EXEC;
            nxt_s.dec = dec;
            nxt_s.taken = takenNow;
            nxt_s.op = opByte;
            nxt_s.elapsed = CNT_ONE;
            // Taken branch adds exactly one cycle to the base count
            nxt_s.remain = dec.cyc + {3'h0, takenNow} - CNT_ONE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_ff <= SEQ_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign opDone = lastCyc;
    assign busy = (s_ff.st == ST_EXEC);
    assign branchTaken = s_ff.taken;
    assign illegalOp = busy && !s_ff.dec.legal;
    assign cycleIndex = s_ff.elapsed;
    assign curOp = s_ff.op;
    assign instrInfo = s_ff.dec;

    // ==================================================================
    // Checks
    // ==================================================================
    logic [3:0] hiN;
    logic [3:0] loN;
    logic isArith;
    logic isLogic;
    logic incOne;
    logic logOne;

    assign hiN = opByte[7:4];
    assign loN = opByte[3:0];
    assign isArith = (hiN == 4'h2) || (hiN == 4'h3) || (hiN == 4'h9);
    assign isLogic = (hiN >= 4'h4) && (hiN <= 4'h6);
    assign incOne = (loN == 4'h4) || loN[3];
    assign logOne = loN[3];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_one;
        opDone;
    endsequence

    sequence s_two;
        !opDone ##1 opDone;
    endsequence

    sequence s_three;
        !opDone [*2] ##1 opDone;
    endsequence

    property p_flags;
        accept && isArith && (loN >= 4'h4)
            |=> instrInfo.flags == FLG_ALL;
    endproperty
    a_flags: assert property (p_flags)
        else $error("arith flag mask wrong");

    property p_start;
        accept |=> busy && (cycleIndex == CNT_ONE);
    endproperty
    a_start: assert property (p_start)
        else $error("instruction did not start in next cycle");

    property p_len_match;
        opDone && curOp[3] && !instrInfo.cond
            |-> cycleIndex == {2'h0, instrInfo.len};
    endproperty
    a_len_match: assert property (p_len_match)
        else $error("cycles differ from byte length");

    property p_branch;
        opDone && instrInfo.cond
            |-> cycleIndex == instrInfo.cyc + {3'h0, branchTaken};
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch timing wrong");

    property p_max;
        busy |-> (cycleIndex <= MAX_CYCLES) && (cycleIndex != CNT_ZERO);
    endproperty
    a_max: assert property (p_max)
        else $error("instruction longer than limit");

    property p_legal;
        accept && (opByte != OP_RESERVED) |=> instrInfo.legal;
    endproperty
    a_legal: assert property (p_legal)
        else $error("defined opcode flagged illegal");

    property p_arith_reg;
        accept && isArith && loN[3]
            |=> s_one and (instrInfo.len == 2'h1);
    endproperty
    a_arith_reg: assert property (p_arith_reg)
        else $error("register arithmetic timing wrong");

    property p_arith_dir;
        accept && isArith && (loN == 4'h5)
            |=> s_two and (instrInfo.len == 2'h2);
    endproperty
    a_arith_dir: assert property (p_arith_dir)
        else $error("direct arithmetic timing wrong");

    property p_arith_ind;
        accept && isArith && (loN[3:1] == 3'h3)
            |=> s_two and (instrInfo.len == 2'h1);
    endproperty
    a_arith_ind: assert property (p_arith_ind)
        else $error("indirect arithmetic timing wrong");

    property p_arith_imm;
        accept && isArith && (loN == 4'h4)
            |=> s_two and (instrInfo.len == 2'h2);
    endproperty
    a_arith_imm: assert property (p_arith_imm)
        else $error("immediate arithmetic timing wrong");

    property p_incdec;
        accept && (hiN <= 4'h1) && (loN >= 4'h4)
            |=> if ($past(incOne)) s_one else s_two;
    endproperty
    a_incdec: assert property (p_incdec)
        else $error("increment or decrement timing wrong");

    property p_inc_ptr;
        accept && (opByte == OP_INC_DATA_PTR)
            |=> s_one and (instrInfo.len == 2'h1);
    endproperty
    a_inc_ptr: assert property (p_inc_ptr)
        else $error("data pointer increment timing wrong");

    property p_logic_dir_imm;
        accept && isLogic && (loN == 4'h3)
            |=> s_three and (instrInfo.len == 2'h3);
    endproperty
    a_logic_dir_imm: assert property (p_logic_dir_imm)
        else $error("logic immediate to direct timing wrong");

    property p_logic_dir_acc;
        accept && isLogic && (loN == 4'h2)
            |=> s_two and (instrInfo.len == 2'h2);
    endproperty
    a_logic_dir_acc: assert property (p_logic_dir_acc)
        else $error("logic acc to direct timing wrong");

    property p_logic_ind_reg;
        accept && isLogic && (loN[3] || (loN[3:1] == 3'h3))
            |=> if ($past(logOne)) s_one else s_two;
    endproperty
    a_logic_ind_reg: assert property (p_logic_ind_reg)
        else $error("logic indirect or register timing wrong");

    property p_mult;
        accept && (opByte == OP_MULT_ACC_AUX) |=> !opDone [*3] ##1 opDone;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiply not four cycles");

    property p_div;
        accept && (opByte == OP_DIV_ACC_AUX) |=> !opDone [*7] ##1 opDone;
    endproperty
    a_div: assert property (p_div)
        else $error("divide not eight cycles");

endmodule

// File: shared/mcit_pkg.sv
// Purpose: Shared constants and types for the instruction timing core.
// Assumes: One system clock, synchronous active-high reset.
// Notes:   Cycle counts are system clock cycles, no machine cycles.
package mcit_pkg;

    // ==================================================================
    // Opcodes referenced by name
    // ==================================================================
    localparam logic [7:0] OP_MULT_ACC_AUX = 8'hA4;
    localparam logic [7:0] OP_DIV_ACC_AUX = 8'h84;
    localparam logic [7:0] OP_INC_DATA_PTR = 8'hA3;
    localparam logic [7:0] OP_RESERVED = 8'hA5;

    // ==================================================================
    // Counts and limits
    // ==================================================================
    localparam int NUM_INSTRUCTIONS = 109;
    localparam logic [3:0] MAX_CYCLES = 4'h8;
    localparam logic [3:0] CYC_MULT = 4'h4;
    localparam logic [3:0] CYC_DIV = 4'h8;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ==================================================================
    // Status-word flag mask: bit 2 carry, bit 1 aux carry, bit 0 overflow
    // ==================================================================
    localparam int FLG_CY_POS = 2;
    localparam int FLG_AC_POS = 1;
    localparam int FLG_OV_POS = 0;
    localparam logic [2:0] FLG_NONE = 3'h0;
    localparam logic [2:0] FLG_CY = 3'h4;
    localparam logic [2:0] FLG_CYOV = 3'h5;
    localparam logic [2:0] FLG_ALL = 3'h7;

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [2:0] {
        CL_MISC, CL_ARITH, CL_LOGIC, CL_MOVE, CL_BOOL, CL_BRANCH
    } mcit_class_e;

    typedef enum logic [2:0] {
        AM_NONE, AM_ACC, AM_REG, AM_DIR, AM_IND, AM_IMM
    } mcit_mode_e;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cyc;
        logic cond;
        logic legal;
        mcit_class_e cls;
        mcit_mode_e mode;
        logic [2:0] flags;
    } mcit_dec_s;

    typedef enum logic {ST_IDLE, ST_EXEC} mcit_state_e;

    typedef struct packed {
        mcit_state_e st;
        logic [3:0] remain;
        logic [3:0] elapsed;
        mcit_dec_s dec;
        logic taken;
        logic [7:0] op;
    } mcit_seq_s;

    localparam mcit_seq_s SEQ_RESET = '0;

endpackage

// File: rtl/mcit_decoder.sv
// Purpose: Opcode to length, cycle count, class, mode and flag mask.
// Assumes: Purely combinational, fed by the offered opcode byte, feeds the sequencer.
// Notes:   Conditional branches report their not-taken cycle count.
module mcit_decoder
    import mcit_pkg::*;
(
    input wire logic [7:0] opByte, // Opcode byte
    output mcit_dec_s dec          // Decoded timing and attributes
);

    logic [3:0] hi;
    logic [3:0] lo;
    logic arith;
    logic logi;

    function automatic mcit_dec_s mk(input logic [1:0] l,
                                     input logic [3:0] c,
                                     input mcit_class_e k,
                                     input mcit_mode_e m);
        mcit_dec_s r;
        r = '0;
        r.len = l;
        r.cyc = c;
        r.legal = 1'b1;
        r.cls = k;
        r.mode = m;
        r.flags = FLG_NONE;
        return r;
    endfunction

    assign hi = opByte[7:4];
    assign lo = opByte[3:0];

    // ==================================================================
    // Opcode table, organised by low nibble column
    // ==================================================================
    always_comb begin
        arith = (hi == 4'h2) || (hi == 4'h3) || (hi == 4'h9);
        logi = (hi >= 4'h4) && (hi <= 4'h6);
        dec = mk(2'h1, 4'h1, CL_MISC, AM_NONE);
        if (lo[3]) begin
            dec = mk(2'h1, 4'h1, CL_MOVE, AM_REG);
            case (hi)
                4'h7, 4'h8, 4'hA: dec = mk(2'h2, 4'h2, CL_MOVE, AM_REG);
                4'hB: begin
                    dec = mk(2'h3, 4'h3, CL_BRANCH, AM_REG);
                    dec.flags = FLG_CY;
                end
                4'hD: dec = mk(2'h2, 4'h2, CL_BRANCH, AM_REG);
                default: dec.mode = AM_REG;
            endcase
            dec.cond = (hi == 4'hB) || (hi == 4'hD);
        end else if (lo[3:1] == 3'h3) begin
            dec = mk(2'h1, 4'h2, CL_MOVE, AM_IND);
            case (hi)
                4'h7, 4'h8, 4'hA: dec = mk(2'h2, 4'h2, CL_MOVE, AM_IND);
                4'hB: begin
                    dec = mk(2'h3, 4'h4, CL_BRANCH, AM_IND);
                    dec.cond = 1'b1;
                    dec.flags = FLG_CY;
                end
                default: dec.mode = AM_IND;
            endcase
        end else begin
            case (lo)
                4'h5: begin
                    dec = mk(2'h2, 4'h2, CL_MOVE, AM_DIR);
                    case (hi)
                        4'h7, 4'h8: dec = mk(2'h3, 4'h3, CL_MOVE, AM_DIR);
                        4'hA: dec.legal = 1'b0;
                        4'hB: begin
                            dec = mk(2'h3, 4'h4, CL_BRANCH, AM_DIR);
                            dec.cond = 1'b1;
                            dec.flags = FLG_CY;
                        end
                        4'hD: begin
                            dec = mk(2'h3, 4'h3, CL_BRANCH, AM_DIR);
                            dec.cond = 1'b1;
                        end
                        default: dec.mode = AM_DIR;
                    endcase
                    if (!dec.legal) begin
                        dec = mk(2'h1, 4'h1, CL_MISC, AM_NONE);
                        dec.legal = 1'b0;
                    end
                end
                4'h4: begin
                    dec = mk(2'h2, 4'h2, CL_MOVE, AM_IMM);
                    case (hi)
                        4'h0, 4'h1, 4'hC, 4'hE, 4'hF:
                            dec = mk(2'h1, 4'h1, CL_MISC, AM_ACC);
                        4'hD: begin
                            dec = mk(2'h1, 4'h1, CL_MISC, AM_ACC);
                            dec.flags = FLG_CY;
                        end
                        4'h8: begin
                            dec = mk(2'h1, CYC_DIV, CL_ARITH, AM_ACC);
                            dec.flags = FLG_CYOV;
                        end
                        4'hA: begin
                            dec = mk(2'h1, CYC_MULT, CL_ARITH, AM_ACC);
                            dec.flags = FLG_CYOV;
                        end
                        4'hB: begin
                            dec = mk(2'h3, 4'h3, CL_BRANCH, AM_IMM);
                            dec.cond = 1'b1;
                            dec.flags = FLG_CY;
                        end
                        default: dec.mode = AM_IMM;
                    endcase
                end
                4'h3: begin
                    case (hi)
                        4'h0, 4'h2: dec = mk(2'h1, 4'h1, CL_MISC, AM_ACC);
                        4'h1, 4'h3: begin
                            dec = mk(2'h1, 4'h1, CL_MISC, AM_ACC);
                            dec.flags = FLG_CY;
                        end
                        4'h4, 4'h5, 4'h6:
                            dec = mk(2'h3, 4'h3, CL_LOGIC, AM_DIR);
                        4'h7: dec = mk(2'h1, 4'h3, CL_BRANCH, AM_NONE);
                        4'hA: begin
                            dec = mk(2'h1, 4'h1, CL_ARITH, AM_NONE);
                            dec.flags = FLG_NONE;
                        end
                        4'hB, 4'hC, 4'hD: begin
                            dec = mk(2'h1, 4'h1, CL_BOOL, AM_NONE);
                            dec.flags = FLG_CY;
                        end
                        default: dec = mk(2'h1, 4'h3, CL_MOVE, AM_IND);
                    endcase
                end
                4'h2: begin
                    case (hi)
                        4'h0, 4'h1: dec = mk(2'h3, 4'h4, CL_BRANCH, AM_NONE);
                        4'h2, 4'h3: dec = mk(2'h1, 4'h5, CL_BRANCH, AM_NONE);
                        4'h4, 4'h5, 4'h6:
                            dec = mk(2'h2, 4'h2, CL_LOGIC, AM_DIR);
                        4'h7, 4'h8, 4'hA: begin
                            dec = mk(2'h2, 4'h2, CL_BOOL, AM_DIR);
                            dec.flags = FLG_CY;
                        end
                        4'hE, 4'hF: dec = mk(2'h1, 4'h3, CL_MOVE, AM_IND);
                        default: dec = mk(2'h2, 4'h2, CL_BOOL, AM_DIR);
                    endcase
                end
                4'h1: dec = mk(2'h2, 4'h3, CL_BRANCH, AM_NONE);
                default: begin
                    case (hi)
                        4'h0: dec = mk(2'h1, 4'h1, CL_MISC, AM_NONE);
                        4'h1, 4'h2, 4'h3: begin
                            dec = mk(2'h3, 4'h3, CL_BRANCH, AM_DIR);
                            dec.cond = 1'b1;
                        end
                        4'h4, 4'h5, 4'h6, 4'h7: begin
                            dec = mk(2'h2, 4'h2, CL_BRANCH, AM_NONE);
                            dec.cond = 1'b1;
                        end
                        4'h8: dec = mk(2'h2, 4'h3, CL_BRANCH, AM_NONE);
                        4'h9: dec = mk(2'h3, 4'h3, CL_MOVE, AM_IMM);
                        4'hA, 4'hB: begin
                            dec = mk(2'h2, 4'h2, CL_BOOL, AM_DIR);
                            dec.flags = FLG_CY;
                        end
                        4'hC, 4'hD: dec = mk(2'h2, 4'h2, CL_MOVE, AM_DIR);
                        default: dec = mk(2'h1, 4'h3, CL_MOVE, AM_NONE);
                    endcase
                end
            endcase
        end
        // Accumulator arithmetic columns get class and full flag mask, logic and inc/dec columns class only
        if ((lo >= 4'h4) && dec.legal && (hi != 4'h8) && (hi != 4'hA)) begin
            if (arith) begin
                dec.cls = CL_ARITH;
                dec.flags = FLG_ALL;
            end else if (logi) begin
                dec.cls = CL_LOGIC;
            end else if (hi <= 4'h1) begin
                dec.cls = CL_ARITH;
            end
        end
    end

endmodule

// File: testbench/mcit_prog_mem.sv
// Purpose: Program memory model that offers queued opcodes to the core.
// Assumes: Bench queues one condition and opcode word per instruction.
// Notes:   Idle lines show the inverse of the last value, not a stale op.
module mcit_prog_mem (
    input wire logic mclk,           // System clock
    input wire logic rst,            // Synchronous reset
    input wire logic pushReq,        // Queue one word
    input wire logic [8:0] pushWord, // Condition and opcode
    input wire logic stall,          // Hold back the next opcode
    input wire logic opReady,        // Core takes an opcode
    output logic opValid,            // Opcode offered
    output logic [7:0] opByte,       // Opcode byte
    output logic condTrue            // Branch condition
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] fifo[$];
    initial begin
        opValid = 1'b0;
        opByte = 8'h00;
        condTrue = 1'b0;
    end
    // ==================================================================
    // Offer the head word until the core takes it
    // ==================================================================
    always @(posedge mclk) begin
        if (rst) begin
            fifo.delete();
        end else begin
            if (opValid && opReady) begin
                void'(fifo.pop_front());
            end
            if (pushReq) begin
                fifo.push_back(pushWord);
            end
        end
        if (fifo.size() != 0 && !stall && !rst) begin
            opValid <= 1'b1;
            opByte <= fifo[0][7:0];
            condTrue <= fifo[0][8];
        end else begin
            opValid <= 1'b0;
            opByte <= ~opByte;
            condTrue <= ~condTrue;
        end
    end
endmodule

// File: testbench/mcit_core_timing_tb_top.sv
// Purpose: Self-checking bench for instruction cycle timing.
// Assumes: Opcodes come from the program memory model.
// Notes:   Durations are edges from take to the opDone sample.
module mcit_core_timing_tb_top
    import mcit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, pushReq, stall, opValid, condTrue, opReady, opDone;
    logic busy, branchTaken, illegalOp, illAtDone;
    logic [8:0] pushWord;
    logic [7:0] opByte, curOp;
    logic [3:0] cycleIndex, idxAtDone;
    mcit_dec_s instrInfo;
    int cnt, mismatches, cmp_count;
    int takeAt[$];
    int doneAt[$];
    mcit_prog_mem u_mcit_prog_mem (.mclk(mclk), .rst(rst),
        .pushReq(pushReq), .pushWord(pushWord), .stall(stall),
        .opReady(opReady), .opValid(opValid), .opByte(opByte),
        .condTrue(condTrue));
    mcit_core_timing u_mcit_core_timing (.mclk(mclk), .rst(rst),
        .opValid(opValid), .opByte(opByte), .condTrue(condTrue),
        .opReady(opReady), .opDone(opDone), .busy(busy),
        .branchTaken(branchTaken), .illegalOp(illegalOp),
        .cycleIndex(cycleIndex), .curOp(curOp), .instrInfo(instrInfo));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ==================================================================
    // Record take and completion edges
    // ==================================================================
    always @(posedge mclk) begin
        if (!rst && opValid === 1'b1 && opReady === 1'b1) begin
            takeAt.push_back(cnt);
        end
        if (!rst && opDone === 1'b1) begin
            doneAt.push_back(cnt);
            idxAtDone = cycleIndex;
            illAtDone = illegalOp;
        end
        cnt++;
    end
    // ==================================================================
    // Shared tasks
    // ==================================================================
    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask
    task automatic push(input logic [7:0] op, input logic cond);
        @(posedge mclk);
        pushReq <= 1'b1;
        pushWord <= {cond, op};
        @(posedge mclk);
        pushReq <= 1'b0;
    endtask
    task automatic wait_done(input int k);
        for (int i = 0; i < 40 && doneAt.size() < k; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(doneAt.size() >= k, "no completion");
    endtask
    task automatic t_op(input logic [7:0] op, input logic cond,
        input logic [1:0] len, input int n, input logic [2:0] fl);
        int k;
        k = doneAt.size();
        push(op, cond);
        wait_done(k + 1);
        chk(doneAt[k] - takeAt[k] == n, "cycle count");
        chk(idxAtDone === 4'(n) && cycleIndex === 4'(n) && busy === 1'b0,
            "cycle index at end");
        chk(instrInfo.len === len && curOp === op, "length or opcode");
        chk(instrInfo.flags === fl, "flag mask");
        chk(instrInfo.legal === 1'b1 && branchTaken === cond, "attributes");
    endtask
    // ==================================================================
    // Scenarios
    // ==================================================================
    task automatic t_reset();
        chk(busy === 1'b0 && opDone === 1'b0 && opReady === 1'b1, "idle");
        chk(instrInfo === '0 && cycleIndex === 4'h0, "reset values");
        $display("test reset done");
    endtask
    task automatic t_arith();
        t_op(8'h28, 1'b0, 2'h1, 1, FLG_ALL);
        t_op(8'h38, 1'b0, 2'h1, 1, FLG_ALL);
        t_op(8'h98, 1'b0, 2'h1, 1, FLG_ALL);
        t_op(8'h35, 1'b0, 2'h2, 2, FLG_ALL);
        t_op(8'h96, 1'b0, 2'h1, 2, FLG_ALL);
        t_op(8'h24, 1'b0, 2'h2, 2, FLG_ALL);
        t_op(8'h04, 1'b0, 2'h1, 1, FLG_NONE);
        t_op(8'h1F, 1'b0, 2'h1, 1, FLG_NONE);
        t_op(8'h05, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'h17, 1'b0, 2'h1, 2, FLG_NONE);
        t_op(OP_INC_DATA_PTR, 1'b0, 2'h1, 1, FLG_NONE);
        t_op(OP_MULT_ACC_AUX, 1'b0, 2'h1, 4, FLG_CYOV);
        t_op(OP_DIV_ACC_AUX, 1'b0, 2'h1, 8, FLG_CYOV);
        $display("test arithmetic done");
    endtask
    task automatic t_logic();
        t_op(8'h53, 1'b0, 2'h3, 3, FLG_NONE);
        t_op(8'h43, 1'b0, 2'h3, 3, FLG_NONE);
        t_op(8'h63, 1'b0, 2'h3, 3, FLG_NONE);
        t_op(8'h52, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'h42, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'h62, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'h57, 1'b0, 2'h1, 2, FLG_NONE);
        t_op(8'h68, 1'b0, 2'h1, 1, FLG_NONE);
        $display("test logic done");
    endtask
    task automatic t_branch();
        t_op(8'h60, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'h60, 1'b1, 2'h2, 3, FLG_NONE);
        t_op(8'h40, 1'b1, 2'h2, 3, FLG_NONE);
        t_op(8'h40, 1'b0, 2'h2, 2, FLG_NONE);
        t_op(8'hB5, 1'b1, 2'h3, 5, FLG_CY);
        t_op(8'hB5, 1'b0, 2'h3, 4, FLG_CY);
        t_op(8'hD8, 1'b1, 2'h2, 3, FLG_NONE);
        t_op(8'h20, 1'b1, 2'h3, 4, FLG_NONE);
        $display("test branch done");
    endtask
    task automatic t_burst();
        int k;
        k = doneAt.size();
        @(posedge mclk);
        stall <= 1'b1;
        push(OP_MULT_ACC_AUX, 1'b0);
        push(8'h28, 1'b0);
        push(8'h26, 1'b0);
        stall <= 1'b0;
        wait_done(k + 3);
        chk(takeAt[k + 1] == doneAt[k], "no back to back take");
        chk(doneAt[k] - takeAt[k] == 4, "multiply in burst");
        chk(doneAt[k + 1] - doneAt[k] == 1, "spacing one");
        chk(doneAt[k + 2] - doneAt[k + 1] == 2, "spacing two");
        $display("test burst done");
    endtask
    task automatic t_sweep();
        int k, d, nLegal;
        nLegal = 0;
        for (int op = 0; op < 256; op++) begin
            k = doneAt.size();
            push(8'(op), 1'b0);
            wait_done(k + 1);
            d = doneAt[k] - takeAt[k];
            if (instrInfo.legal === 1'b1) begin
                nLegal++;
            end
            chk(d >= 1 && d <= int'(MAX_CYCLES), "cycle bound");
            if (op[3] && instrInfo.cond === 1'b0) begin
                chk(d == int'(instrInfo.len), "bytes vs cycles");
            end
            if (8'(op) == OP_RESERVED) begin
                chk(illAtDone === 1'b1 && d == 1, "reserved op");
            end
        end
        chk(nLegal == 255, "legal opcode count");
        $display("test sweep done");
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #100us;
        mismatches++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        pushReq = 1'b0;
        pushWord = 9'h000;
        stall = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        t_reset();
        t_arith();
        t_logic();
        t_branch();
        t_burst();
        t_sweep();
        final_report();
    end
endmodule
